// ---- rtl/adcc_consts.vh ----
// adcc_consts.vh: offsets, field positions, reset values and codes
// assumes: included by the converter control design files only
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// register byte offsets
`define ADCC_OFS_CTRL 8'h00
`define ADCC_OFS_CHAN 8'h04
`define ADCC_OFS_CLKDIV 8'h08
`define ADCC_OFS_GROUP 8'h0C
`define ADCC_OFS_INTF 8'h10
`define ADCC_OFS_INTE 8'h14
`define ADCC_OFS_RESULT 8'h18

// control register fields
`define ADCC_CTRL_ON 0
`define ADCC_CTRL_GO 1
`define ADCC_CTRL_REPEAT 2
`define ADCC_CTRL_INCFG 3
`define ADCC_CTRL_CS 4
`define ADCC_CTRL_NEGREF 5
`define ADCC_CTRL_POSREF_LO 6
`define ADCC_CTRL_POSREF_HI 7
`define ADCC_CTRL_BUSY 8

// channel register fields
`define ADCC_CHAN_POS_LO 0
`define ADCC_CHAN_POS_HI 5
`define ADCC_CHAN_NEG_LO 8
`define ADCC_CHAN_NEG_HI 13

// interrupt flag / enable fields
`define ADCC_INTF_DONE 0
`define ADCC_INTE_DONE 0
`define ADCC_INTE_PERIPH 1
`define ADCC_INTE_GLOBAL 2

// channel codes
`define ADCC_CH_GROUP 6'h3E
`define ADCC_CH_GROUND 6'h3C

// reset values
`define ADCC_RST_CH 6'h00
`define ADCC_RST_DIV 6'h00
`define ADCC_RST_POS_REFERENCE_SEL 2'h0
`define ADCC_RST_CODE 12'h000

// conversion timing
`define ADCC_NBITS 12
`define ADCC_TOP_BIT 4'hB
`define ADCC_SE_START 12'h800

`endif

// ---- rtl/adcc_sync.v ----
// adcc_sync.v: two-flop synchroniser for levels from outside pclk
// assumes: inputs are slow levels, each bit crossed on its own
`timescale 1ns/100ps
module adcc_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // adcc_sync

// ---- rtl/adcc_tick.v ----
// adcc_tick.v: converter bit-clock tick, divided pclk or rc rising edge
// assumes: rc_lvl already synchronised to pclk; div held during a run
`timescale 1ns/100ps
`include "adcc_consts.vh"
module adcc_tick (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire use_rc,
  input wire rc_lvl,
  input wire [5:0] div,
  output reg tick
);
  reg [6:0] cnt_q;
  reg rc_prev_q;
  wire [6:0] lim;
  wire rc_rise;

  // period of 2(n+1) pclk cycles
  assign lim = {div, 1'b1};
  assign rc_rise = rc_lvl & ~rc_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
      rc_prev_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      rc_prev_q <= rc_lvl;
      if (!run) begin
        cnt_q <= 7'h00;
        tick <= 1'b0;
      end else if (use_rc) begin
        cnt_q <= 7'h00;
        tick <= rc_rise;
      end else if (cnt_q == lim) begin
        cnt_q <= 7'h00;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 7'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule // adcc_tick

// ---- rtl/adcc_ctrl.v ----
// adcc_ctrl.v: converter control: apb registers, input muxing, sar, irq
// assumes: apb master on pclk; comparator and rc clock arrive as pins
// Operation
// - input config 1 converts positive minus negative, signed result
// - input config 0 converts positive against ground, ignores negative
// - selected pin is sampled whatever its analog-select bit says
// - per-port group enable bits connect port inputs into the group
// - enabled group inputs wire-OR onto one selectable positive channel
// - multi-bit positive reference field, single-bit negative reference
// - clock-source bit 1 picks rc clock, 0 picks divided pclk
// - divider n gives pclk divided by 2(n+1)
// - one result bit resolved per converter clock period
// - control logic follows selected clock; rc adds write delay; here registers and sequencer run on pclk, with no added write delay
// - done flag set after every conversion regardless of enable
// - hardware never clears done flag; software clears it
// - interrupt request only when done flag and enable both set; here the peripheral enable must be set as well
// - conversions run in sleep only on the rc clock
// - sleep, enables set, global off: wake without service routine
// - sleep, all enables set: wake, then vector to service routine
// - module must be on before a conversion can start
// - start bit cleared at completion unless repeat mode is set
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "adcc_consts.vh"
module adcc_ctrl #(
  parameter NPORTS = 3,
  parameter PORTW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rc_clk_in,
  input wire comp_in,
  input wire sleep_in,
  output reg [5:0] pos_channel_sel_o,
  output reg [5:0] neg_channel_sel_o,
  output reg [NPORTS*PORTW-1:0] group_connect_o,
  output reg [1:0] pos_reference_sel_o,
  output reg neg_reference_sel_o,
  output reg diff_mode_o,
  output reg rc_osc_en_o,
  output reg sample_o,
  output reg [11:0] dac_code_o,
  output reg int_req_o,
  output reg wake_o,
  output reg isr_req_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SAMP = 2'h1;
  localparam ST_CONV = 2'h2;

  reg on_q, go_q, rep_q, input_config_sel_q, cs_q, neg_reference_sel_q;
  reg [1:0] pos_reference_sel_q;
  reg [5:0] pos_channel_sel_q, neg_channel_sel_q, div_q;
  reg [NPORTS*PORTW-1:0] grp_q;
  reg flag_q, ie_q, pe_q, ge_q;
  reg [11:0] result_q;
  reg [1:0] state_q;
  reg [3:0] idx_q;
  reg done_q;
  reg go_d, flag_d;
  reg [11:0] code_n;
  reg [31:0] rd_d;
  reg hit_d;

  wire rc_s, comp_s, tick, access, wr, run, fin, clr_req, irq;
  wire [31:0] grp_word;

  adcc_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({rc_clk_in, comp_in}),
    .q({rc_s, comp_s})
  );

  // stop the divided clock in sleep, rc keeps running
  assign run = (state_q != ST_IDLE) & ~(sleep_in & ~cs_q);

  adcc_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .use_rc(cs_q),
    .rc_lvl(rc_s),
    .div(div_q),
    .tick(tick)
  );

  // bus side: one wait state, write lands when pready is seen
  assign access = psel & penable;
  assign wr = access & pwrite & pready;
  assign fin = (state_q == ST_CONV) & tick & (idx_q == 4'h0);
  assign clr_req = wr & (paddr == `ADCC_OFS_INTF) &
    pwdata[`ADCC_INTF_DONE];
  assign irq = flag_q & ie_q & pe_q;
  assign grp_word = {{(32-NPORTS*PORTW){1'b0}}, grp_q};

  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `ADCC_OFS_CTRL: begin
        rd_d[`ADCC_CTRL_ON] = on_q;
        rd_d[`ADCC_CTRL_GO] = go_q;
        rd_d[`ADCC_CTRL_REPEAT] = rep_q;
        rd_d[`ADCC_CTRL_INCFG] = input_config_sel_q;
        rd_d[`ADCC_CTRL_CS] = cs_q;
        rd_d[`ADCC_CTRL_NEGREF] = neg_reference_sel_q;
        rd_d[`ADCC_CTRL_POSREF_HI:`ADCC_CTRL_POSREF_LO] =
          pos_reference_sel_q;
        rd_d[`ADCC_CTRL_BUSY] = (state_q != ST_IDLE);
      end
      `ADCC_OFS_CHAN: begin
        rd_d[`ADCC_CHAN_POS_HI:`ADCC_CHAN_POS_LO] = pos_channel_sel_q;
        rd_d[`ADCC_CHAN_NEG_HI:`ADCC_CHAN_NEG_LO] = neg_channel_sel_q;
      end
      `ADCC_OFS_CLKDIV: rd_d[5:0] = div_q;
      `ADCC_OFS_GROUP: rd_d = grp_word;
      `ADCC_OFS_INTF: rd_d[`ADCC_INTF_DONE] = flag_q;
      `ADCC_OFS_INTE: begin
        rd_d[`ADCC_INTE_DONE] = ie_q;
        rd_d[`ADCC_INTE_PERIPH] = pe_q;
        rd_d[`ADCC_INTE_GLOBAL] = ge_q;
      end
      `ADCC_OFS_RESULT: rd_d[11:0] = result_q;
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit_d;
      if (access & ~pready & ~pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // next trial code: keep/drop the bit under test, try the next one
  always @* begin
    code_n = dac_code_o;
    if (input_config_sel_q && idx_q == `ADCC_TOP_BIT) begin
      code_n[11] = ~comp_s;
      code_n[10] = 1'b1;
    end else begin
      code_n[idx_q] = comp_s;
      if (idx_q != 4'h0) begin
        code_n[idx_q - 4'h1] = 1'b1;
      end
    end
  end

  always @* begin
    go_d = go_q;
    if (wr && paddr == `ADCC_OFS_CTRL) begin
      go_d = pwdata[`ADCC_CTRL_GO] & pwdata[`ADCC_CTRL_ON];
    end else if (!on_q) begin
      go_d = 1'b0;
    end else if (fin && !rep_q) begin
      go_d = 1'b0;
    end
  end

  always @* begin
    flag_d = done_q | (flag_q & ~clr_req);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
      go_q <= 1'b0;
      rep_q <= 1'b0;
      input_config_sel_q <= 1'b0;
      cs_q <= 1'b0;
      neg_reference_sel_q <= 1'b0;
      pos_reference_sel_q <= `ADCC_RST_POS_REFERENCE_SEL;
      pos_channel_sel_q <= `ADCC_RST_CH;
      neg_channel_sel_q <= `ADCC_RST_CH;
      div_q <= `ADCC_RST_DIV;
      grp_q <= {(NPORTS*PORTW){1'b0}};
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      pe_q <= 1'b0;
      ge_q <= 1'b0;
    end else begin
      go_q <= go_d;
      flag_q <= flag_d;
      if (wr) begin
        case (paddr)
          `ADCC_OFS_CTRL: begin
            on_q <= pwdata[`ADCC_CTRL_ON];
            rep_q <= pwdata[`ADCC_CTRL_REPEAT];
            input_config_sel_q <= pwdata[`ADCC_CTRL_INCFG];
            cs_q <= pwdata[`ADCC_CTRL_CS];
            neg_reference_sel_q <= pwdata[`ADCC_CTRL_NEGREF];
            pos_reference_sel_q <=
              pwdata[`ADCC_CTRL_POSREF_HI:`ADCC_CTRL_POSREF_LO];
          end
          `ADCC_OFS_CHAN: begin
            pos_channel_sel_q <=
              pwdata[`ADCC_CHAN_POS_HI:`ADCC_CHAN_POS_LO];
            neg_channel_sel_q <=
              pwdata[`ADCC_CHAN_NEG_HI:`ADCC_CHAN_NEG_LO];
          end
          `ADCC_OFS_CLKDIV: div_q <= pwdata[5:0];
          `ADCC_OFS_GROUP: grp_q <= pwdata[NPORTS*PORTW-1:0];
          `ADCC_OFS_INTE: begin
            ie_q <= pwdata[`ADCC_INTE_DONE];
            pe_q <= pwdata[`ADCC_INTE_PERIPH];
            ge_q <= pwdata[`ADCC_INTE_GLOBAL];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // sar sequencer: sample on one tick, then twelve bit ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
      done_q <= 1'b0;
      sample_o <= 1'b0;
      dac_code_o <= `ADCC_RST_CODE;
      result_q <= `ADCC_RST_CODE;
    end else begin
      done_q <= fin;
      case (state_q)
        ST_IDLE: begin
          if (on_q && go_q) begin
            state_q <= ST_SAMP;
            sample_o <= 1'b1;
          end
        end
        ST_SAMP: begin
          if (!go_q || !on_q) begin
            state_q <= ST_IDLE;
            sample_o <= 1'b0;
          end else if (tick) begin
            state_q <= ST_CONV;
            sample_o <= 1'b0;
            idx_q <= `ADCC_TOP_BIT;
            dac_code_o <= input_config_sel_q ? `ADCC_RST_CODE :
              `ADCC_SE_START;
          end
        end
        ST_CONV: begin
          if (!go_q || !on_q) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            dac_code_o <= code_n;
            idx_q <= idx_q - 4'h1;
            if (idx_q == 4'h0) begin
              state_q <= ST_IDLE;
              result_q <= code_n;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // analog muxing and interrupt outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_channel_sel_o <= `ADCC_RST_CH;
      neg_channel_sel_o <= `ADCC_CH_GROUND;
      group_connect_o <= {(NPORTS*PORTW){1'b0}};
      pos_reference_sel_o <= `ADCC_RST_POS_REFERENCE_SEL;
      neg_reference_sel_o <= 1'b0;
      diff_mode_o <= 1'b0;
      rc_osc_en_o <= 1'b0;
      int_req_o <= 1'b0;
      wake_o <= 1'b0;
      isr_req_o <= 1'b0;
    end else begin
      // pin analog-select is not consulted
      pos_channel_sel_o <= pos_channel_sel_q;
      neg_channel_sel_o <= input_config_sel_q ? neg_channel_sel_q :
        `ADCC_CH_GROUND;
      group_connect_o <= grp_q &
        {(NPORTS*PORTW){pos_channel_sel_q == `ADCC_CH_GROUP}};
      pos_reference_sel_o <= pos_reference_sel_q;
      neg_reference_sel_o <= neg_reference_sel_q;
      diff_mode_o <= input_config_sel_q;
      rc_osc_en_o <= on_q & cs_q;
      int_req_o <= irq;
      wake_o <= irq & sleep_in;
      isr_req_o <= irq & ge_q;
    end
  end
endmodule // adcc_ctrl

// ---- tb/adcc_asserts.sv ----
// adcc_asserts.sv: port checks for the converter control
// assumes: bound to adcc_ctrl, ports joined by name
`timescale 1ns/100ps
module adcc_asserts #(
  parameter NPORTS = 3,
  parameter PORTW = 8
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic pready,
  input logic sleep_in,
  input logic [5:0] pos_channel_sel_o,
  input logic [5:0] neg_channel_sel_o,
  input logic [NPORTS*PORTW-1:0] group_connect_o,
  input logic [1:0] pos_reference_sel_o,
  input logic diff_mode_o,
  input logic rc_osc_en_o,
  input logic sample_o,
  input logic [11:0] dac_code_o,
  input logic int_req_o,
  input logic wake_o,
  input logic isr_req_o
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wctl = psel && penable && pready && pwrite && paddr == 8'h00;
  sequence s_acc;
    !pready ##1 pready && psel && penable;
  endsequence
  sequence s_irq;
    ##[0:1] int_req_o;
  endsequence
  a_apb_wait: assert property ($rose(penable) && psel |-> s_acc)
    else $error("apb answer not after one wait");
  a_neg_ground: assert property (
    !diff_mode_o && $past(!diff_mode_o) |-> neg_channel_sel_o == 6'h3C)
    else $error("single-ended negative not ground");
  a_group_gate: assert property (
    pos_channel_sel_o != 6'h3E && $past(pos_channel_sel_o != 6'h3E)
    |-> group_connect_o == '0) else $error("group joined while unselected");
  a_ref_write: assert property ($changed(pos_reference_sel_o) |->
    $past(wctl) || $past(wctl, 2)) else $error("reference moved unasked");
  a_wake_cause: assert property (
    $rose(wake_o) |-> $past(sleep_in) ##[0:1] int_req_o)
    else $error("wake without request in sleep");
  a_isr_cause: assert property ($rose(isr_req_o) |-> s_irq)
    else $error("service request without interrupt");
  a_sample_ends: assert property (
    $rose(sample_o) && !sleep_in |-> ##[1:200] !sample_o)
    else $error("sample phase never ended");
  a_sleep_freeze: assert property (
    (sleep_in && !rc_osc_en_o)[*3] |-> $stable(dac_code_o))
    else $error("divided clock ran in sleep");
endmodule // adcc_asserts
bind adcc_ctrl adcc_asserts #(.NPORTS(NPORTS), .PORTW(PORTW)) u_chk (.*);

// ---- tb/adcc_analog.sv ----
// adcc_analog.sv: analog side: channel levels, comparator, rc clock
// assumes: half-lsb offset so either comparator sense gives one code
`timescale 1ns/100ps
module adcc_analog (
  input logic [5:0] pos_sel,
  input logic [5:0] neg_sel,
  input logic grp_on,
  input logic diff,
  input logic [11:0] dac,
  input logic rc_en,
  output logic comp,
  output logic rc_clk
);
  int vp;
  int vn;
  function automatic int lvl(input logic [5:0] c, input logic g);
    if (c == 6'h3E)
      return g ? 2469 : 0;
    if (c == 6'h3C)
      return 0;
    return c * 64 + 5;
  endfunction
  always_comb begin
    vp = lvl(pos_sel, grp_on);
    vn = lvl(neg_sel, grp_on);
    // sign bit set: magnitude is judged on negative minus positive
    if (diff)
      comp = (dac[11] ? 2 * (vn - vp) : 2 * (vp - vn)) + 1 >
        2 * int'(dac[10:0]);
    else
      comp = 2 * vp + 1 > 2 * int'(dac);
  end
  // rc clock stands low while the converter keeps it off
  initial begin
    rc_clk = 1'h0;
    #7;
    forever #125 rc_clk = rc_en & ~rc_clk;
  end
endmodule // adcc_analog

// ---- tb/adcc_ctrl_tb_top.sv ----
// adcc_ctrl_tb_top.sv: directed bench for the converter control
// assumes: adcc_analog drives the comparator and the rc clock
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  err_total++; $display("wrong value %0t %h %h", $time, a, b); \
  end end
module adcc_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic rc_clk_in, comp_in, sleep_in, diff_mode_o, neg_reference_sel_o;
  logic rc_osc_en_o, sample_o, int_req_o, wake_o, isr_req_o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pos_channel_sel_o, neg_channel_sel_o;
  logic [23:0] group_connect_o;
  logic [1:0] pos_reference_sel_o;
  logic [11:0] dac_code_o, d0;
  int err_total, n_compared, cyc, k;
  adcc_ctrl dut (.*);
  adcc_analog u_ana (
    .pos_sel(pos_channel_sel_o),
    .neg_sel(neg_channel_sel_o),
    .grp_on(|group_connect_o),
    .diff(diff_mode_o),
    .dac(dac_code_o),
    .rc_en(rc_osc_en_o),
    .comp(comp_in),
    .rc_clk(rc_clk_in)
  );
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic go(input logic [31:0] c);
    wr(8'h00, c);
    repeat (20) @(posedge pclk);
    wr(8'h00, c | 32'h2);
    while (sample_o !== 1'h1) @(posedge pclk);
    while (sample_o !== 1'h0) @(posedge pclk);
  endtask
  task automatic fin;
    do bus(1'h0, 8'h10, 32'h0); while (rd[0] !== 1'h1);
  endtask
  task automatic t_regs;
    `CHK(neg_channel_sel_o, 6'h3C)
    rdc(8'h18, 32'h0);
    bus(1'h1, 8'h1C, 32'h5);
    `CHK(er, 1'h1)
    wr(8'h00, 32'h2);
    rdc(8'h00, 32'h0);
    wr(8'h00, 32'hF0);
    @(posedge pclk);
    `CHK(pos_reference_sel_o, 2'h3)
    `CHK(neg_reference_sel_o, 1'h1)
    `CHK(rc_osc_en_o, 1'h0)
    wr(8'h00, 32'h11);
    @(posedge pclk);
    `CHK(rc_osc_en_o, 1'h1)
    $display("regs done");
  endtask
  task automatic t_div;
    logic [5:0] ns [3];
    logic [5:0] cs [3];
    ns = '{6'h00, 6'h01, 6'h3F};
    cs = '{6'h05, 6'h0A, 6'h3E};
    wr(8'h0C, 32'h100);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, {26'h0, ns[i]});
      wr(8'h04, {26'h0, cs[i]});
      @(posedge pclk);
      `CHK(group_connect_o, cs[i] == 6'h3E ? 24'h100 : 24'h0)
      `CHK(pos_channel_sel_o, cs[i])
      go(32'h1);
      d0 = dac_code_o;
      while (dac_code_o === d0) @(posedge pclk);
      d0 = dac_code_o;
      k = 0;
      while (dac_code_o === d0) begin
        @(posedge pclk);
        k++;
      end
      `CHK(k, 2 * (ns[i] + 1))
      fin;
      if (i > 0)
        rdc(8'h18, cs[i] == 6'h3E ? 32'h9A5 : cs[i] * 64 + 5);
      rdc(8'h00, 32'h1);
      wr(8'h10, 32'h1);
    end
    $display("divider done");
  endtask
  task automatic t_diff;
    wr(8'h08, 32'h1);
    wr(8'h04, 32'h0220);
    go(32'h9);
    `CHK(neg_channel_sel_o, 6'h02)
    `CHK(diff_mode_o, 1'h1)
    fin;
    rdc(8'h18, 32'h780);
    wr(8'h10, 32'h1);
    wr(8'h04, 32'h2002);
    go(32'h9);
    fin;
    rdc(8'h18, 32'hF80);
    wr(8'h10, 32'h1);
    go(32'h1);
    `CHK(neg_channel_sel_o, 6'h3C)
    fin;
    rdc(8'h18, 32'h85);
    wr(8'h10, 32'h1);
    $display("diff done");
  endtask
  task automatic t_irq;
    go(32'h1);
    fin;
    repeat (40) @(posedge pclk);
    rdc(8'h10, 32'h1);
    `CHK(int_req_o, 1'h0)
    wr(8'h14, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(int_req_o, 1'h1)
    `CHK(isr_req_o, 1'h0)
    wr(8'h14, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(isr_req_o, 1'h1)
    wr(8'h10, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(int_req_o, 1'h0)
    wr(8'h14, 32'h3);
    $display("irq done");
  endtask
  task automatic t_sleep;
    go(32'h1);
    sleep_in <= 1'h1;
    repeat (300) @(posedge pclk);
    rdc(8'h10, 32'h0);
    `CHK(wake_o, 1'h0)
    sleep_in <= 1'h0;
    fin;
    wr(8'h10, 32'h1);
    go(32'h11);
    sleep_in <= 1'h1;
    while (wake_o !== 1'h1) @(posedge pclk);
    `CHK(isr_req_o, 1'h0)
    rdc(8'h18, 32'h85);
    wr(8'h14, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(isr_req_o, 1'h1)
    `CHK(wake_o, 1'h1)
    sleep_in <= 1'h0;
    wr(8'h10, 32'h1);
    wr(8'h14, 32'h0);
    $display("sleep done");
  endtask
  task automatic t_rep;
    go(32'h5);
    fin;
    bus(1'h0, 8'h00, 32'h0);
    `CHK(rd[1], 1'h1)
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h3C);
    go(32'h1);
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h1);
    repeat (100) @(posedge pclk);
    rdc(8'h10, 32'h0);
    $display("repeat done");
  endtask
  task automatic stop_test;
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_in} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_div;
    t_diff;
    t_irq;
    t_sleep;
    t_rep;
    stop_test;
  end
endmodule // adcc_ctrl_tb_top
